//--- logic/cam_maint_pkg.sv
// package: constants, command codes and carriers for the table maintenance block
package cam_maint_pkg;
    localparam int ENTRIES = 16;
    localparam int IDX_W = 4;
    localparam int SEG_W = 2;
    localparam int AP_W = IDX_W + SEG_W;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    localparam int CMD_W = 4;

    // register byte addresses
    localparam logic [BUS_AW-1:0] OFS_CMD = 8'h00;
    localparam logic [BUS_AW-1:0] OFS_MODE = 8'h04;
    localparam logic [BUS_AW-1:0] OFS_ADDR_PTR = 8'h08;
    localparam logic [BUS_AW-1:0] OFS_HIT_PTR = 8'h0C;
    localparam logic [BUS_AW-1:0] OFS_EMPTY_PTR = 8'h10;
    localparam logic [BUS_AW-1:0] OFS_EMPTY_STATUS = 8'h14;
    localparam logic [BUS_AW-1:0] OFS_EMPTY_BITS = 8'h18;
    localparam logic [BUS_AW-1:0] OFS_ACCESS_BITS = 8'h1C;
    localparam logic [BUS_AW-1:0] OFS_HIT_FLAGS = 8'h20;

    // field positions
    localparam int MODE_DEVSEL_BIT = 0;
    localparam int STAT_EMPTY_FOUND_BIT = 0;
    localparam int STAT_HIT_FOUND_BIT = 1;

    // reset values, scan start and step, head segment
    localparam logic [ENTRIES-1:0] RST_ALL_ONES = 16'hFFFF;
    localparam logic [ENTRIES-1:0] RST_ALL_ZERO = 16'h0000;
    localparam logic [IDX_W:0] IDX_STEP = 5'h01;
    localparam logic [IDX_W:0] IDX_FIRST = 5'h00;
    localparam logic [SEG_W-1:0] HEAD_SEG = 2'h0;

    typedef enum logic [CMD_W-1:0] {
        PURGE_ALL_CMD = 4'h1,
        PURGE_UNACCESSED_CMD = 4'h2,
        PURGE_ACCESSED_CMD = 4'h3,
        PURGE_UNACCESSED_HIT_CMD = 4'h4,
        PURGE_ACCESSED_HIT_CMD = 4'h5,
        PURGE_HIT_HEAD_CMD = 4'h6,
        PURGE_AT_POINTER_CMD = 4'h7,
        CLEAR_ACCESS_CMD = 4'h8,
        CLEAR_ACCESS_ON_HIT_CMD = 4'h9,
        RESTORE_CMD = 4'hA,
        ADVANCE_EMPTY_CMD = 4'hB,
        REBUILD_EMPTY_CMD = 4'hC,
        ADVANCE_HIT_CMD = 4'hD,
        REBUILD_HIT_CMD = 4'hE
    } cmd_e;

    // per-entry state bits, bit i belongs to entry i (entry 0 has top priority)
    typedef struct packed {
        logic [ENTRIES-1:0] empty;
        logic [ENTRIES-1:0] access;
        logic [ENTRIES-1:0] hit;
    } table_s;

    // priority pointer: entry index plus a flag that an entry was found
    typedef struct packed {
        logic [IDX_W-1:0] idx;
        logic found;
    } ptr_s;

    localparam ptr_s RST_EMPTY_PTR = '{idx: 4'h0, found: 1'b1};
    localparam ptr_s RST_HIT_PTR = '{idx: 4'h0, found: 1'b0};
endpackage

//--- logic/cam_table_maint.sv
// table maintenance command logic: purge, restore, access clear and pointer commands
`timescale 1ns/1ps
`default_nettype none
module cam_table_maint
    import cam_maint_pkg::*;
(
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic [BUS_AW-1:0] ADDR,
    input wire logic [BUS_DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic HIGHER_HIT,
    output logic [BUS_DW-1:0] RDATA,
    output logic TABLE_FULL_N
);

    // highest-priority set bit at or after start
    function automatic ptr_s first_set(input logic [ENTRIES-1:0] vec,
                                       input logic [IDX_W:0] start);
        ptr_s r;
        r = RST_HIT_PTR;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (vec[i] && (i >= int'(start))) begin
                r.found = 1'b1;
                r.idx = IDX_W'(i);
            end
        end
        return r;
    endfunction

    // entry index to head-segment address
    function automatic logic [AP_W-1:0] entry_addr(input logic [IDX_W-1:0] idx);
        return {idx, HEAD_SEG};
    endfunction

    table_s tbl;
    table_s next_tbl;
    ptr_s hit_ptr;
    ptr_s next_hit_ptr;
    ptr_s empty_ptr;
    ptr_s next_empty_ptr;
    logic full_n;
    logic next_full_n;
    logic dev_select;
    logic next_dev_select;
    logic [AP_W-1:0] addr_ptr;
    logic [AP_W-1:0] next_addr_ptr;
    logic [BUS_DW-1:0] rdata;
    logic [BUS_DW-1:0] next_rdata;

    logic cmd_go;
    cmd_e cmd;
    logic [ENTRIES-1:0] live_hit;
    logic [IDX_W-1:0] ap_idx;
    logic ap_head;
    ptr_s scan_empty;
    ptr_s scan_hit;
    ptr_s step_empty;
    ptr_s step_hit;
    logic head_purge_ok;

    // command decode and priority scans
    assign cmd_go = WR && (ADDR == OFS_CMD);
    assign cmd = cmd_e'(WDATA[CMD_W-1:0]);
    assign live_hit = tbl.hit & ~tbl.empty;
    assign ap_idx = addr_ptr[AP_W-1:SEG_W];
    assign ap_head = (addr_ptr[SEG_W-1:0] == HEAD_SEG);
    assign scan_empty = first_set(tbl.empty, IDX_FIRST);
    assign scan_hit = first_set(live_hit, IDX_FIRST);
    assign step_empty = first_set(tbl.empty, {1'b0, empty_ptr.idx} + IDX_STEP);
    assign step_hit = first_set(live_hit, {1'b0, hit_ptr.idx} + IDX_STEP);
    assign head_purge_ok = hit_ptr.found && (dev_select || !HIGHER_HIT);

    // table bits, pointers and full pin: next values
    always_comb begin
        next_tbl = tbl;
        next_hit_ptr = hit_ptr;
        next_empty_ptr = empty_ptr;
        next_full_n = full_n;
        // host loads entry state directly (registration and search results)
        if (WR && (ADDR == OFS_EMPTY_BITS)) begin
            next_tbl.empty = WDATA[ENTRIES-1:0];
        end
        if (WR && (ADDR == OFS_ACCESS_BITS)) begin
            next_tbl.access = WDATA[ENTRIES-1:0];
        end
        if (WR && (ADDR == OFS_HIT_FLAGS)) begin
            next_tbl.hit = WDATA[ENTRIES-1:0];
        end
        // every command finishes in one edge, so nothing is pending afterwards
        if (cmd_go) begin
            unique case (cmd)
                PURGE_ALL_CMD: begin
                    next_tbl.empty = RST_ALL_ONES;
                    next_tbl.access = RST_ALL_ZERO;
                end
                PURGE_UNACCESSED_CMD: begin
                    next_tbl.empty = tbl.empty | ~tbl.access;
                    next_tbl.access = RST_ALL_ZERO;
                end
                PURGE_ACCESSED_CMD: begin
                    next_tbl.empty = tbl.empty | tbl.access;
                    next_tbl.access = RST_ALL_ZERO;
                end
                PURGE_UNACCESSED_HIT_CMD: begin
                    next_tbl.empty = tbl.empty | (tbl.hit & ~tbl.access);
                    next_tbl.access = tbl.access & ~tbl.hit;
                end
                PURGE_ACCESSED_HIT_CMD: begin
                    next_tbl.empty = tbl.empty | (tbl.hit & tbl.access);
                    next_tbl.access = tbl.access & ~tbl.hit;
                end
                PURGE_HIT_HEAD_CMD: begin
                    if (head_purge_ok) begin
                        next_tbl.empty[hit_ptr.idx] = 1'b1;
                        next_tbl.access[hit_ptr.idx] = 1'b0;
                    end
                end
                PURGE_AT_POINTER_CMD: begin
                    if (dev_select && ap_head) begin
                        next_tbl.empty[ap_idx] = 1'b1;
                        next_tbl.access[ap_idx] = 1'b0;
                    end
                end
                CLEAR_ACCESS_CMD: begin
                    next_tbl.access = RST_ALL_ZERO;
                end
                CLEAR_ACCESS_ON_HIT_CMD: begin
                    next_tbl.access = tbl.access & ~tbl.hit;
                end
                RESTORE_CMD: begin
                    if (dev_select && ap_head) begin
                        next_tbl.empty[ap_idx] = 1'b0;
                    end
                end
                ADVANCE_EMPTY_CMD: begin
                    next_empty_ptr.found = step_empty.found;
                    if (step_empty.found) begin
                        next_empty_ptr.idx = step_empty.idx;
                    end
                    next_full_n = step_empty.found;
                end
                REBUILD_EMPTY_CMD: begin
                    next_empty_ptr.found = scan_empty.found;
                    if (scan_empty.found) begin
                        next_empty_ptr.idx = scan_empty.idx;
                    end
                    next_full_n = scan_empty.found;
                end
                ADVANCE_HIT_CMD: begin
                    next_hit_ptr.found = step_hit.found;
                    if (step_hit.found) begin
                        next_hit_ptr.idx = step_hit.idx;
                    end
                end
                REBUILD_HIT_CMD: begin
                    next_hit_ptr.found = scan_hit.found;
                    if (scan_hit.found) begin
                        next_hit_ptr.idx = scan_hit.idx;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // table bits, pointers and full pin: registers
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            tbl <= '{empty: RST_ALL_ONES, access: RST_ALL_ZERO, hit: RST_ALL_ZERO};
            hit_ptr <= RST_HIT_PTR;
            empty_ptr <= RST_EMPTY_PTR;
            full_n <= 1'b1;
        end else begin
            tbl <= next_tbl;
            hit_ptr <= next_hit_ptr;
            empty_ptr <= next_empty_ptr;
            full_n <= next_full_n;
        end
    end

    // control registers and read data: next values
    always_comb begin
        next_dev_select = dev_select;
        next_addr_ptr = addr_ptr;
        next_rdata = '0;
        if (WR && (ADDR == OFS_MODE)) begin
            next_dev_select = WDATA[MODE_DEVSEL_BIT];
        end
        if (WR && (ADDR == OFS_ADDR_PTR)) begin
            next_addr_ptr = WDATA[AP_W-1:0];
        end
        if (RD) begin
            unique case (ADDR)
                OFS_MODE: next_rdata[MODE_DEVSEL_BIT] = dev_select;
                OFS_ADDR_PTR: next_rdata[AP_W-1:0] = addr_ptr;
                OFS_HIT_PTR: next_rdata[AP_W-1:0] = entry_addr(hit_ptr.idx);
                OFS_EMPTY_PTR: next_rdata[AP_W-1:0] = entry_addr(empty_ptr.idx);
                OFS_EMPTY_STATUS: begin
                    next_rdata[STAT_EMPTY_FOUND_BIT] = empty_ptr.found;
                    next_rdata[STAT_HIT_FOUND_BIT] = hit_ptr.found;
                end
                OFS_EMPTY_BITS: next_rdata[ENTRIES-1:0] = tbl.empty;
                OFS_ACCESS_BITS: next_rdata[ENTRIES-1:0] = tbl.access;
                OFS_HIT_FLAGS: next_rdata[ENTRIES-1:0] = tbl.hit;
                default: next_rdata = '0;
            endcase
        end
    end

    // control registers and read data: registers
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            dev_select <= 1'b0;
            addr_ptr <= '0;
            rdata <= '0;
        end else begin
            dev_select <= next_dev_select;
            addr_ptr <= next_addr_ptr;
            rdata <= next_rdata;
        end
    end

    // outputs straight from flip-flops
    assign RDATA = rdata;
    assign TABLE_FULL_N = full_n;

    // checks on the command effects
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);

    logic is_purge;
    assign is_purge = cmd_go && (cmd inside {PURGE_ALL_CMD, PURGE_UNACCESSED_CMD,
        PURGE_ACCESSED_CMD, PURGE_UNACCESSED_HIT_CMD, PURGE_ACCESSED_HIT_CMD,
        PURGE_HIT_HEAD_CMD, PURGE_AT_POINTER_CMD});

    purge_all_a: assert property (cmd_go && cmd == PURGE_ALL_CMD |=>
        tbl.empty == RST_ALL_ONES && tbl.access == RST_ALL_ZERO)
        else $error("purge-all left an entry valid or an access bit set");

    purge_keeps_hit_a: assert property (is_purge |=>
        tbl.hit == $past(tbl.hit))
        else $error("purge changed hit flags");

    purge_unacc_a: assert property (cmd_go && cmd == PURGE_UNACCESSED_CMD |=>
        tbl.empty == ($past(tbl.empty) | ~$past(tbl.access)))
        else $error("purge-unaccessed chose wrong entries");

    hit_purge_a: assert property (cmd_go && cmd == PURGE_ACCESSED_HIT_CMD |=>
        tbl.empty == ($past(tbl.empty) | ($past(tbl.hit) & $past(tbl.access)))
        && tbl.access == ($past(tbl.access) & ~$past(tbl.hit)))
        else $error("purge-accessed-hit wrong");

    clear_access_a: assert property (cmd_go && cmd == CLEAR_ACCESS_CMD |=>
        tbl.access == RST_ALL_ZERO && $stable(tbl.empty))
        else $error("clear-access wrong");

    empty_ptr_hold_a: assert property (is_purge || (cmd_go && cmd == RESTORE_CMD)
        |=> $stable(empty_ptr) ##1 1'b1)
        else $error("empty pointer moved on purge or restore");

    hit_ptr_hold_a: assert property (is_purge |=> $stable(hit_ptr))
        else $error("hit pointer moved on purge");

    restore_gate_a: assert property (cmd_go && cmd == RESTORE_CMD && !dev_select
        && !(WR && ADDR == OFS_EMPTY_BITS) |=> $stable(tbl.empty))
        else $error("restore acted in broadcast mode");

    rebuild_empty_a: assert property (cmd_go && cmd == REBUILD_EMPTY_CMD |=>
        TABLE_FULL_N == (|$past(tbl.empty)) && empty_ptr.found == TABLE_FULL_N)
        else $error("rebuild-empty left pointer and pin apart");

    rebuild_hit_a: assert property (cmd_go && cmd == REBUILD_HIT_CMD |=>
        hit_ptr.found == (|$past(live_hit))
        && (!hit_ptr.found || 1'($past(live_hit) >> hit_ptr.idx))
        && ($past(live_hit) & ~(RST_ALL_ONES << hit_ptr.idx)) == RST_ALL_ZERO)
        else $error("rebuild-hit chose a dead entry");

    unacc_hit_purge_a: assert property (cmd_go && cmd == PURGE_UNACCESSED_HIT_CMD |=>
        tbl.empty == ($past(tbl.empty) | ($past(tbl.hit) & ~$past(tbl.access)))
        && tbl.access == ($past(tbl.access) & ~$past(tbl.hit)))
        else $error("purge-unaccessed-hit wrong");

    clear_on_hit_a: assert property (cmd_go && cmd == CLEAR_ACCESS_ON_HIT_CMD |=>
        tbl.access == ($past(tbl.access) & ~$past(tbl.hit)) && $stable(tbl.empty))
        else $error("clear-access-on-hit wrong");

    restore_entry_a: assert property (cmd_go && cmd == RESTORE_CMD
        && dev_select && ap_head |=> !tbl.empty[$past(ap_idx)])
        else $error("restore left its entry empty");

    ptr_purge_a: assert property (cmd_go && cmd == PURGE_AT_POINTER_CMD
        && dev_select && ap_head |=> tbl.empty[$past(ap_idx)] && !tbl.access[$past(ap_idx)])
        else $error("pointer purge missed its entry");

    advance_empty_a: assert property (cmd_go && cmd == ADVANCE_EMPTY_CMD |=>
        empty_ptr.found == (|($past(tbl.empty) >> ({1'b0, $past(empty_ptr.idx)} + IDX_STEP)))
        && (!empty_ptr.found || (empty_ptr.idx > $past(empty_ptr.idx)
        && 1'($past(tbl.empty) >> empty_ptr.idx))))
        else $error("advance-empty missed the next empty entry");

    full_pin_a: assert property (TABLE_FULL_N == empty_ptr.found)
        else $error("full pin and empty pointer disagree");

    purge_acc_a: assert property (cmd_go && cmd == PURGE_ACCESSED_CMD |=>
        tbl.empty == ($past(tbl.empty) | $past(tbl.access)) && tbl.access == RST_ALL_ZERO)
        else $error("purge-accessed chose wrong entries");

    head_purge_a: assert property (cmd_go && cmd == PURGE_HIT_HEAD_CMD
        && head_purge_ok |=> tbl.empty[$past(hit_ptr.idx)]
        && !tbl.access[$past(hit_ptr.idx)])
        else $error("hit-head purge missed its entry");

    read_once_a: assert property (!RD |=> RDATA == '0)
        else $error("read data outside the answer cycle");

    purge_then_rebuild_c: cover property (is_purge ##[1:4]
        (cmd_go && cmd == REBUILD_EMPTY_CMD));
    table_full_c: cover property (cmd_go && cmd == REBUILD_EMPTY_CMD ##1 !TABLE_FULL_N);
    advance_hit_c: cover property (cmd_go && cmd == ADVANCE_HIT_CMD ##1 hit_ptr.found);
    restore_done_c: cover property (cmd_go && cmd == RESTORE_CMD && dev_select);

endmodule
`default_nettype wire

//--- tb/cam_host.sv
// host cpu model: drives the register port of the table maintenance block
`timescale 1ns/1ps
`default_nettype none
module cam_host
    import cam_maint_pkg::*;
(
    input wire logic clock,
    input wire logic [BUS_DW-1:0] rdata,
    output var logic [BUS_AW-1:0] addr,
    output var logic [BUS_DW-1:0] wdata,
    output var logic wr,
    output var logic rd
);
    // idle bus at time zero
    initial begin
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // one-cycle write; address and data scrambled once the strobe drops
    task automatic write_reg(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~v;
    endtask

    // one-cycle read; data taken in the cycle after the strobe
    task automatic read_reg(input logic [BUS_AW-1:0] a, output logic [BUS_DW-1:0] v);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        addr <= ~a;
        #1 v = rdata;
    endtask

    // pointer-based command: select device, load head address, run, then rebuild
    task automatic by_pointer(input int idx, input logic [CMD_W-1:0] code);
        write_reg(OFS_MODE, 32'h0000_0001);
        write_reg(OFS_ADDR_PTR, 32'(idx * 4));
        write_reg(OFS_CMD, 32'(code));
        write_reg(OFS_CMD, 32'(REBUILD_EMPTY_CMD));
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench: directed and random command traffic against a behavioural table model
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb_top import cam_maint_pkg::*;;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic higher_hit = 1'b0;
    logic [BUS_AW-1:0] addr;
    logic [BUS_DW-1:0] wdata, rdata, d, r;
    logic wr, rd, full_n;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 32'h0000_5cf3;
    int m_empty, m_access, m_hit, h_idx, h_found, e_idx, e_found, devsel, aptr;
    int walk[6] = '{13, 14, 6, 14, 11, 12};

    always #25 clock = ~clock;

    cam_table_maint DUT (.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .HIGHER_HIT(higher_hit), .RDATA(rdata), .TABLE_FULL_N(full_n));
    cam_host host (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    // first entry at or after from whose bit is set, -1 if none
    function automatic int first_set(input int mask, input int from);
        for (int i = from; i < ENTRIES; i++) begin
            if (mask[i]) return i;
        end
        return -1;
    endfunction

    // pointer move: found flag follows the search, index kept when nothing found
    task automatic step(inout int idx, inout int found, input int hit);
        found = (hit >= 0);
        if (hit >= 0) idx = hit;
    endtask

    // model reacts to one taken write
    task automatic model_write(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] v);
        int b;
        int live;
        b = 1 << aptr[5:2];
        live = m_hit & ~m_empty;
        case (a)
            OFS_MODE: devsel = v[0];
            OFS_ADDR_PTR: aptr = v[5:0];
            OFS_EMPTY_BITS: m_empty = v[15:0];
            OFS_ACCESS_BITS: m_access = v[15:0];
            OFS_HIT_FLAGS: m_hit = v[15:0];
            OFS_CMD: begin
                case (v[3:0])
                    PURGE_ALL_CMD: m_empty = 32'h0000_ffff;
                    PURGE_UNACCESSED_CMD: m_empty |= ~m_access;
                    PURGE_ACCESSED_CMD: m_empty |= m_access;
                    PURGE_UNACCESSED_HIT_CMD: m_empty |= m_hit & ~m_access;
                    PURGE_ACCESSED_HIT_CMD: m_empty |= m_hit & m_access;
                    PURGE_HIT_HEAD_CMD: begin
                        if (h_found && (devsel || !higher_hit)) begin
                            m_empty |= 1 << h_idx;
                            m_access &= ~(1 << h_idx);
                        end
                    end
                    PURGE_AT_POINTER_CMD: begin
                        if (devsel && aptr[1:0] == 0) begin
                            m_empty |= b;
                            m_access &= ~b;
                        end
                    end
                    RESTORE_CMD: if (devsel && aptr[1:0] == 0) m_empty &= ~b;
                    ADVANCE_EMPTY_CMD: step(e_idx, e_found, first_set(m_empty, e_idx + 1));
                    REBUILD_EMPTY_CMD: step(e_idx, e_found, first_set(m_empty, 0));
                    ADVANCE_HIT_CMD: step(h_idx, h_found, first_set(live, h_idx + 1));
                    REBUILD_HIT_CMD: step(h_idx, h_found, first_set(live, 0));
                    default: ;
                endcase
                if (v[3:0] inside {[1:3], 8}) m_access = 0;
                if (v[3:0] inside {4, 5, 9}) m_access &= ~m_hit;
            end
            default: ;
        endcase
    endtask

    // model follows every write at the edge that takes it
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            m_empty = 32'h0000_ffff;
            m_access = 0;
            m_hit = 0;
            h_idx = 0;
            h_found = 0;
            e_idx = 0;
            e_found = 1;
            devsel = 0;
            aptr = 0;
        end else if (wr === 1'b1) begin
            model_write(addr, wdata);
        end
    end

    // reads every visible piece of state and compares it with the model
    task automatic check_all();
        host.read_reg(OFS_EMPTY_BITS, d);
        `CHK("empty bits", m_empty & 32'h0000_ffff, d)
        host.read_reg(OFS_ACCESS_BITS, d);
        `CHK("access bits", m_access & 32'h0000_ffff, d)
        host.read_reg(OFS_HIT_FLAGS, d);
        `CHK("hit flags", m_hit & 32'h0000_ffff, d)
        host.read_reg(OFS_EMPTY_STATUS, d);
        `CHK("status", (h_found << 1) | e_found, d & 32'h0000_0003)
        `CHK("full pin", e_found, full_n)
        host.read_reg(OFS_HIT_PTR, d);
        `CHK("hit pointer", h_idx * 4, d)
        host.read_reg(OFS_EMPTY_PTR, d);
        `CHK("empty pointer", e_idx * 4, d)
        host.read_reg(OFS_MODE, d);
        `CHK("mode", devsel, d)
        host.read_reg(OFS_ADDR_PTR, d);
        `CHK("address pointer", aptr, d)
    endtask

    // example table: entries 0..5 valid, access on 3 and 5, hits on 1 and 3
    task automatic load_table();
        host.write_reg(OFS_MODE, 32'h0000_0001);
        host.write_reg(OFS_EMPTY_BITS, 32'h0000_ffc0);
        host.write_reg(OFS_ACCESS_BITS, 32'h0000_0028);
        host.write_reg(OFS_HIT_FLAGS, 32'h0000_000a);
        host.write_reg(OFS_ADDR_PTR, 32'h0000_000c);
        host.write_reg(OFS_CMD, 32'(REBUILD_HIT_CMD));
        host.write_reg(OFS_CMD, 32'(REBUILD_EMPTY_CMD));
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog against a hung run
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        check_all();
        @(posedge clock);
        #1 `CHK("idle read data", 0, rdata)
        host.read_reg(8'h24, d);
        `CHK("unmapped read", 0, d)
        host.write_reg(8'h24, 32'h0000_ffff);
        // every code on the example table, unused codes included
        for (int c = 0; c < 16; c++) begin
            load_table();
            host.write_reg(OFS_CMD, 32'(c));
            check_all();
        end
        // advance, rewind, purge the head hit, rescan: pointer holds until rebuilt
        load_table();
        foreach (walk[i]) begin
            host.write_reg(OFS_CMD, 32'(walk[i]));
            check_all();
        end
        // single-entry purge and restore through the address pointer
        host.by_pointer(2, PURGE_AT_POINTER_CMD);
        check_all();
        host.by_pointer(2, RESTORE_CMD);
        check_all();
        // random register and command traffic, broadcast and device-select alike
        for (int n = 0; n < 300; n++) begin
            r = $random(seed);
            @(posedge clock);
            higher_hit <= r[31];
            case (r[2:0])
                0: host.write_reg(OFS_EMPTY_BITS, $random(seed));
                1: host.write_reg(OFS_ACCESS_BITS, $random(seed));
                2: host.write_reg(OFS_HIT_FLAGS, $random(seed));
                3: host.write_reg(OFS_MODE, 32'(r[8]));
                4: host.write_reg(OFS_ADDR_PTR, 32'(r[13:8] & (r[14] ? 6'h3f : 6'h3c)));
                default: host.write_reg(OFS_CMD, r);
            endcase
            check_all();
        end
        end_sim();
    end
endmodule
`undef CHK
`default_nettype wire
